// file: rtl/clkgen_pkg.sv
// Purpose: Constants and types for the receiver output-clock generator.
// Assumes: mclk at 125 MHz; the source clocks tick at 1024 times fs.
// Notes:   Function

package clkgen_pkg;

  // Reference frequency and source ticks per frame period
  localparam int unsigned REF_FREQ_HZ     = 24576000;
  localparam int unsigned SRC_TICKS_PER_FS = 1024;
  // Window of reference ticks; measured PLL ticks then equal fs in Hz
  localparam int unsigned MEAS_WINDOW_DEF = REF_FREQ_HZ / SRC_TICKS_PER_FS;

  // Widths
  localparam int FS_W    = 18;  // Measured fs in Hz
  localparam int WIN_W   = 15;  // Window counter
  localparam int CNT_W   = 10;  // Output clock counter
  localparam int REFD_W  = 4;   // Reference output divider counter
  localparam int ADR_W   = 8;   // Bus address width

  // Frequency thresholds in Hz
  localparam logic [FS_W-1:0] FS_AUTO_LOW_HZ  = 18'h0d2f0; // 54 kHz
  localparam logic [FS_W-1:0] FS_AUTO_HIGH_HZ = 18'h1a5e0; // 108 kHz
  localparam logic [FS_W-1:0] FS_MIN_HZ       = 18'h01b58; // 7 kHz
  localparam logic [FS_W-1:0] FS_MAX_HZ       = 18'h34bc0; // 216 kHz

  // System-clock ratio codes
  localparam logic [2:0] RATIO_128 = 3'h0;
  localparam logic [2:0] RATIO_256 = 3'h2;
  localparam logic [2:0] RATIO_512 = 3'h4;

  // Counter bit that carries each output clock
  localparam int SYS_BIT_512 = 0;
  localparam int SYS_BIT_256 = 1;
  localparam int SYS_BIT_128 = 2;
  localparam int BIT_CLK_BIT = 3;
  localparam int FRAME_BIT   = 9;

  // Register byte offsets
  localparam logic [ADR_W-1:0] CTRL_OFS = 8'h00;
  localparam logic [ADR_W-1:0] STAT_OFS = 8'h04;
  localparam logic [ADR_W-1:0] FS_OFS   = 8'h08;

  // Control register layout, bit 0 upward from the bottom field
  typedef struct packed {
    logic [1:0] ref_clk_out_div;      // Bits 9:8
    logic       ref_clk_out_en;       // Bit 7
    logic       ref_osc_auto_stop;    // Bit 6
    logic       wide_mode;            // Bit 5
    logic       ref_src_mode;         // Bit 4
    logic       sysclk_ratio_auto_en; // Bit 3
    logic [2:0] sysclk_ratio_sel;     // Bits 2:0
  } ctrl_t;

  localparam ctrl_t CTRL_RST = '{ref_clk_out_div:      2'h0,
                                 ref_clk_out_en:       1'h0,
                                 ref_osc_auto_stop:    1'h0,
                                 wide_mode:            1'h0,
                                 ref_src_mode:         1'h0,
                                 sysclk_ratio_auto_en: 1'h1,
                                 sysclk_ratio_sel:     3'h0};

  // Status register layout
  typedef struct packed {
    logic       meas_valid;  // Bit 6
    logic       osc_running; // Bit 5
    logic       fs_in_range; // Bit 4
    logic       pll_locked;  // Bit 3
    logic [2:0] eff_ratio;   // Bits 2:0
  } status_t;

endpackage

// file: rtl/tick_counter.sv
// Purpose: Free-running counter that advances on a one-cycle tick.
// Assumes: tick comes from logic on mclk.
// Notes:   Also presents its next value so users can register taps.
`timescale 1ns/1ns
`default_nettype none

module tick_counter #(
  parameter int W = 10
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic         tick,
  output var  logic [W-1:0] count_q,
  output var  logic [W-1:0] count_d
);

  // Next value: one step per tick
  always_comb begin
    count_d = tick ? count_q + 1'b1 : count_q;
  end

  // Register, frozen while ce is low
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      count_q <= '0;
    end else if (ce) begin
      count_q <= count_d;
    end
  end

endmodule

`default_nettype wire

// file: rtl/clk_output_gen.sv
// Purpose: Output system, bit and frame clocks from PLL or reference.
// Assumes: Source clocks are slow enough to be sampled by mclk.
// Notes:   Registers sit behind a classic Wishbone slave.
`timescale 1ns/1ns
`default_nettype none

module clk_output_gen #(
  parameter int unsigned MEAS_WINDOW = clkgen_pkg::MEAS_WINDOW_DEF
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        pll_clk,
  input  wire logic        pll_lock_in,
  input  wire logic        ref_clk_in,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o,
  output var  logic        sys_clk_out,
  output var  logic        bit_clk_out,
  output var  logic        frame_clk_out,
  output var  logic        ref_osc_drive_out,
  output var  logic [3:0]  multipurpose_pins_a_o,
  output var  logic [3:0]  multipurpose_pins_a_oe
);

  // Synchroniser stages: bit 0 PLL clock, 1 reference, 2 lock
  logic [2:0] sync1_q;    // First stage, read only by second
  logic [2:0] sync2_q;    // Second stage
  logic [2:0] sync3_q;    // Edge-detect history

  // Control and status
  clkgen_pkg::ctrl_t   ctrl_q;       // Control register
  clkgen_pkg::ctrl_t   ctrl_d;
  clkgen_pkg::status_t status;       // Status word
  logic                pll_locked;   // Synchronised lock
  logic                pll_rise;     // PLL clock edge
  logic                ref_rise;     // Reference clock edge
  logic                raw_tick;     // Selected source edge, unguarded
  logic                src_tick;     // Source edge after runt guard
  logic [1:0]          gap_q;        // Cycles since last tick, saturating
  logic [1:0]          gap_d;
  logic [2:0]          eff_ratio;    // Ratio in use

  // Output clock counter
  logic [clkgen_pkg::CNT_W-1:0] cnt_q;  // Output counter
  logic [clkgen_pkg::CNT_W-1:0] cnt_d;
  logic                         sys_q;  // Registered system clock
  logic                         sys_d;

  // Measurement
  logic [clkgen_pkg::WIN_W-1:0] win_q;  // Reference ticks in window
  logic [clkgen_pkg::WIN_W-1:0] win_d;
  logic [clkgen_pkg::FS_W-1:0]  acc_q;  // PLL ticks in window
  logic [clkgen_pkg::FS_W-1:0]  acc_d;
  logic [clkgen_pkg::FS_W-1:0]  fs_q;   // Last measured fs in Hz
  logic [clkgen_pkg::FS_W-1:0]  fs_d;
  logic                         valid_q; // Measurement valid
  logic                         valid_d;
  logic                         in_range; // Fs within decode span

  // Oscillator and reference output
  logic                          osc_run_q;  // Oscillator enabled
  logic                          osc_run_d;
  logic [clkgen_pkg::REFD_W-1:0] refc_q;     // Reference divider
  logic [clkgen_pkg::REFD_W-1:0] refc_d;
  logic                          ref_clk_buffered_out; // Pin driver
  logic                          refo_d;

  // Bus
  logic        ack_q;    // Acknowledge
  logic        ack_d;
  logic [31:0] rdata_q;  // Read data
  logic [31:0] rdata_d;
  logic        req;      // Live bus request

  // Two-flop synchronisers and edge history for all pin inputs
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
      sync3_q <= 3'h0;
    end else if (ce) begin
      sync1_q <= {pll_lock_in, ref_clk_in, pll_clk};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // Edges; a stopped oscillator yields no reference ticks
  assign pll_rise   = sync2_q[0] & ~sync3_q[0];
  assign ref_rise   = sync2_q[1] & ~sync3_q[1] & osc_run_q;
  assign pll_locked = sync2_q[2];

  // Locked or free-running PLL clock, or reference in reference mode
  assign raw_tick = ctrl_q.ref_src_mode ? ref_rise : pll_rise;
  // A tick in the cycle right after the last accepted tick is dropped to avoid a runt phase
  assign src_tick = raw_tick & (gap_q != 2'h0);

  // Ratio in use: auto by measured fs, else the manual field
  always_comb begin
    eff_ratio = clkgen_pkg::RATIO_128;
    if (ctrl_q.sysclk_ratio_auto_en) begin
      if (!pll_locked || !valid_q) begin
        eff_ratio = clkgen_pkg::RATIO_128;
      end else if (fs_q < clkgen_pkg::FS_AUTO_LOW_HZ) begin
        eff_ratio = clkgen_pkg::RATIO_512;
      end else if (fs_q < clkgen_pkg::FS_AUTO_HIGH_HZ) begin
        eff_ratio = clkgen_pkg::RATIO_256;
      end else begin
        eff_ratio = clkgen_pkg::RATIO_128;
      end
    end else if (ctrl_q.sysclk_ratio_sel[2]) begin
      eff_ratio = clkgen_pkg::RATIO_512;
    end else if (ctrl_q.sysclk_ratio_sel[1]) begin
      eff_ratio = clkgen_pkg::RATIO_256;
    end else begin
      eff_ratio = clkgen_pkg::RATIO_128;
    end
  end

  // One counter on the selected source carries every output clock
  tick_counter #(
    .W (clkgen_pkg::CNT_W)
  ) u_out_cnt (
    .mclk    (mclk),
    .rst     (rst),
    .ce      (ce),
    .tick    (src_tick),
    .count_q (cnt_q),
    .count_d (cnt_d)
  );

  // System clock tap; levels only change on a source tick or a change of eff_ratio
  always_comb begin
    gap_d = src_tick ? 2'h0 : gap_q + {1'b0, gap_q != '1};
    case (eff_ratio)
      clkgen_pkg::RATIO_512: sys_d = cnt_d[clkgen_pkg::SYS_BIT_512];
      clkgen_pkg::RATIO_256: sys_d = cnt_d[clkgen_pkg::SYS_BIT_256];
      default:               sys_d = cnt_d[clkgen_pkg::SYS_BIT_128];
    endcase
  end

  // Register the system clock tap
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sys_q <= 1'b0;
      gap_q <= '1;
    end else if (ce) begin
      sys_q <= sys_d;
      gap_q <= gap_d;
    end
  end

  // Bit and frame clocks straight from counter flops, any ratio
  assign sys_clk_out   = sys_q;
  assign bit_clk_out   = cnt_q[clkgen_pkg::BIT_CLK_BIT];
  assign frame_clk_out = cnt_q[clkgen_pkg::FRAME_BIT];

  // Fs measurement: PLL ticks counted over a reference-timed window
  always_comb begin
    win_d   = win_q;
    acc_d   = acc_q;
    fs_d    = fs_q;
    valid_d = valid_q;
    if (!pll_locked) begin
      // No lock: mark the result invalid and restart; fs_q keeps its value
      win_d   = '0;
      acc_d   = '0;
      valid_d = 1'b0;
    end else if (osc_run_q) begin
      if (pll_rise && (acc_q != '1)) begin
        acc_d = acc_q + 1'b1;
      end
      if (ref_rise) begin
        if (win_q == clkgen_pkg::WIN_W'(MEAS_WINDOW - 1)) begin
          // Window closed: publish count as fs in Hz
          fs_d    = acc_d;
          acc_d   = '0;
          win_d   = '0;
          valid_d = 1'b1;
        end else begin
          win_d = win_q + 1'b1;
        end
      end
    end
  end

  // Register the measurement state
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      win_q   <= '0;
      acc_q   <= '0;
      fs_q    <= '0;
      valid_q <= 1'b0;
    end else if (ce) begin
      win_q   <= win_d;
      acc_q   <= acc_d;
      fs_q    <= fs_d;
      valid_q <= valid_d;
    end
  end

  // Decode span flag, independent of ratio setting
  assign in_range = valid_q && (fs_q >= clkgen_pkg::FS_MIN_HZ) &&
                    (fs_q <= clkgen_pkg::FS_MAX_HZ);

  // Oscillator runs unless auto-stop is set and neither wide nor reference-source mode is on
  always_comb begin
    osc_run_d = ctrl_q.wide_mode || ctrl_q.ref_src_mode ||
                !ctrl_q.ref_osc_auto_stop;
  end

  // Reference output divider on reference ticks
  tick_counter #(
    .W (clkgen_pkg::REFD_W)
  ) u_ref_cnt (
    .mclk    (mclk),
    .rst     (rst),
    .ce      (ce),
    .tick    (ref_rise),
    .count_q (refc_q),
    .count_d (refc_d)
  );

  // Divided tap, muted low when disabled
  always_comb begin
    refo_d = ctrl_q.ref_clk_out_en ?
             refc_d[ctrl_q.ref_clk_out_div] : 1'b0;
  end

  // Register oscillator enable and reference output
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      osc_run_q            <= 1'b1;
      ref_clk_buffered_out <= 1'b0;
    end else if (ce) begin
      osc_run_q            <= osc_run_d;
      ref_clk_buffered_out <= refo_d;
    end
  end

  // Oscillator enable and pin group A, bit 0 carries the reference
  assign ref_osc_drive_out      = osc_run_q;
  assign multipurpose_pins_a_o  = {3'h0, ref_clk_buffered_out};
  assign multipurpose_pins_a_oe = {3'h0, ctrl_q.ref_clk_out_en};

  // Status word
  assign status = '{meas_valid:  valid_q,
                    osc_running: osc_run_q,
                    fs_in_range: in_range,
                    pll_locked:  pll_locked,
                    eff_ratio:   eff_ratio};

  // Bus next state: ack one cycle after request, write at ack cycle
  assign req = wb_cyc_i & wb_stb_i;
  always_comb begin
    ctrl_d  = ctrl_q;
    rdata_d = rdata_q;
    ack_d   = req & ~ack_q;
    if (ack_d) begin
      case (wb_adr_i)
        clkgen_pkg::CTRL_OFS: rdata_d = 32'(ctrl_q);
        clkgen_pkg::STAT_OFS: rdata_d = 32'(status);
        clkgen_pkg::FS_OFS:   rdata_d = 32'(fs_q);
        default:              rdata_d = 32'h0;
      endcase
    end
    if (ack_q && req && wb_we_i && (wb_adr_i == clkgen_pkg::CTRL_OFS)) begin
      if (wb_sel_i[0]) begin
        ctrl_d[7:0] = wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        ctrl_d[9:8] = wb_dat_i[9:8];
      end
    end
  end

  // Register the bus state
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_q  <= clkgen_pkg::CTRL_RST;
      ack_q   <= 1'b0;
      rdata_q <= 32'h0;
    end else if (ce) begin
      ctrl_q  <= ctrl_d;
      ack_q   <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

  // Checks on the generated clocks and controls
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  src_pll_sel_a: assert property (ce && !ctrl_q.ref_src_mode && pll_rise &&
    gap_q != 2'h0 |=> cnt_q == $past(cnt_q) + 1'b1)
    else $error("pll edge not counted");

  manual_ratio_a: assert property (!ctrl_q.sysclk_ratio_auto_en &&
    ctrl_q.sysclk_ratio_sel == 3'h4 |-> eff_ratio == 3'h4)
    else $error("manual 512 ignored");

  bit_clk_toggle_a: assert property (ce && src_tick && cnt_q[2:0] == 3'h7
    |=> $changed(bit_clk_out)) else $error("bit clock not 64fs");

  frame_toggle_a: assert property (ce && src_tick && cnt_q[8:0] == 9'h1ff
    |=> $changed(frame_clk_out)) else $error("frame clock not fs");

  auto_unlock_a: assert property (ctrl_q.sysclk_ratio_auto_en && !pll_locked
    |-> eff_ratio == 3'h0) else $error("unlocked not 128fs");

  auto_low_a: assert property (ctrl_q.sysclk_ratio_auto_en && pll_locked &&
    valid_q && fs_q < 18'h0d2f0 |-> eff_ratio == 3'h4)
    else $error("low fs not 512fs");

  range_flag_a: assert property (valid_q && fs_q > 18'h34bc0 |-> !in_range)
    else $error("range flag wrong");

  meas_frozen_a: assert property (ce && !osc_run_q |=> $stable(fs_q))
    else $error("measured without reference");

  src_ref_sel_a: assert property (ce && ctrl_q.ref_src_mode && !ref_rise
    |=> $stable(cnt_q)) else $error("counter moved off reference");

  osc_stop_a: assert property (ce && ctrl_q.ref_osc_auto_stop &&
    !ctrl_q.wide_mode && !ctrl_q.ref_src_mode |=> !ref_osc_drive_out)
    else $error("oscillator not stopped");

  osc_wide_a: assert property (ce && ctrl_q.wide_mode |=> ref_osc_drive_out)
    else $error("wide mode lost reference");

  ref_mute_a: assert property (ce && !ctrl_q.ref_clk_out_en
    |=> !multipurpose_pins_a_o[0]) else $error("reference not muted");

  sys_no_runt_a: assert property (ce && !src_tick && $stable(eff_ratio)
    |=> $stable(sys_clk_out)) else $error("system clock runt");

  ack_single_a: assert property (ack_q |=> !ack_q) else $error("ack stuck");

endmodule

`default_nettype wire

// file: testbench/clk_consumer.sv
// Purpose: Serial-audio consumer that counts output clock edges.
// Assumes: All clocks are slow against mclk and are sampled on it.
// Notes:   Also keeps the shortest sys clock phase seen since clear.
`timescale 1ns/1ns
`default_nettype none

module clk_consumer (
  input  wire logic        mclk,
  input  wire logic        clr,
  input  wire logic        sys_clk,
  input  wire logic        bit_clk,
  input  wire logic        frame_clk,
  output var  logic [15:0] sys_n,
  output var  logic [15:0] bit_n,
  output var  logic [15:0] frame_n,
  output var  logic [7:0]  min_phase
);
  logic [2:0] prev_q; // Clocks seen one cycle ago
  logic [7:0] run_q;  // Length of the current sys phase, 0 = unknown

  // Count rising edges; a partial phase after clear is never measured
  always_ff @(posedge mclk) begin
    prev_q <= {frame_clk, bit_clk, sys_clk};
    if (clr) begin
      sys_n     <= 16'h0;
      bit_n     <= 16'h0;
      frame_n   <= 16'h0;
      min_phase <= 8'hff;
      run_q     <= 8'h0;
    end else begin
      sys_n   <= sys_n + 16'(sys_clk & ~prev_q[0]);
      bit_n   <= bit_n + 16'(bit_clk & ~prev_q[1]);
      frame_n <= frame_n + 16'(frame_clk & ~prev_q[2]);
      // Phase ends: keep it if it is the shortest so far
      if (sys_clk != prev_q[0]) begin
        run_q <= 8'h1;
        if (run_q != 8'h0 && run_q < min_phase) min_phase <= run_q;
      end else if (run_q != 8'h0 && run_q != 8'hff) begin
        run_q <= run_q + 8'h1;
      end
    end
  end
endmodule
`default_nettype wire

// file: testbench/tb.sv
// Purpose: Self-checking bench for the receiver output-clock generator.
// Assumes: Measuring window of 24 reference edges, so FS reads fs/1000.
// Notes:   Source pins are made on the mclk grid; reference is 40 ns.
`timescale 1ns/1ns
`default_nettype none

module tb;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        pll_clk = 1'b0;
  logic        pll_lock_in = 1'b0;
  logic        ref_clk_in = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0]  wb_sel_i = 4'h0;
  logic        wb_we_i = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic [31:0] wb_dat_o, q;         // Read data, last value taken
  logic        wb_ack_o, sys_o, bit_o, frame_o, osc_o;
  logic [3:0]  mp_o, mp_oe;
  logic        clr = 1'b1;          // Clears every edge counter
  logic        ce = 1'b1;           // Clock enable of the design
  logic [15:0] sys_n, bit_n, frame_n;
  logic [7:0]  min_phase;
  logic [2:0]  codes [3] = '{3'h0, 3'h2, 3'h4};
  int          miscompares = 0;
  int          compares = 0;
  int          pll_half = 2;        // PLL half period in mclk cycles
  bit          pll_run = 1'b1;      // PLL pin toggles while set
  int          pc = 0, rc = 0, pll_n = 0, ref_n = 0, mp_n = 0;
  logic        mp_prev = 1'b0;

  clk_output_gen #(.MEAS_WINDOW(24)) dut_u (
    .mclk(mclk), .rst(rst), .ce(ce), .pll_clk(pll_clk),
    .pll_lock_in(pll_lock_in), .ref_clk_in(ref_clk_in),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sys_clk_out(sys_o),
    .bit_clk_out(bit_o), .frame_clk_out(frame_o),
    .ref_osc_drive_out(osc_o), .multipurpose_pins_a_o(mp_o),
    .multipurpose_pins_a_oe(mp_oe));

  clk_consumer consumer_u (
    .mclk(mclk), .clr(clr), .sys_clk(sys_o), .bit_clk(bit_o),
    .frame_clk(frame_o), .sys_n(sys_n), .bit_n(bit_n),
    .frame_n(frame_n), .min_phase(min_phase));

  // 125 MHz clock
  always #4 mclk = ~mclk;

  // Source pins and counts of their rising edges
  always @(posedge mclk) begin
    rc <= (rc == 4) ? 0 : rc + 1;
    ref_clk_in <= (rc < 2);
    if (pll_run) begin
      pc <= (pc >= 2 * pll_half - 1) ? 0 : pc + 1;
      pll_clk <= (pc < pll_half);
    end else begin
      pll_clk <= 1'b0;
    end
    mp_prev <= mp_o[0];
    if (clr) begin
      pll_n <= 0;
      ref_n <= 0;
      mp_n <= 0;
    end else begin
      pll_n <= pll_n + int'(pll_run && pc == 0);
      ref_n <= ref_n + int'(rc == 0);
      mp_n <= mp_n + int'(mp_o[0] === 1'b1 && mp_prev === 1'b0);
    end
  end

  // Verdict and end of run
  task automatic report_and_stop();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input bit ok, input string what);
    compares++;
    if (!ok) begin
      miscompares++;
      $display("MISMATCH t=%0t %s", $time, what);
    end
  endtask

  // Count within one edge of the expected figure; unknown never passes
  function automatic bit near(input logic [15:0] got, input int exp);
    return got >= 16'(exp - 1) && got <= 16'(exp + 1);
  endfunction

  // Output clock period in source edges for a ratio code
  function automatic int div_of(input logic [2:0] c);
    return c[2] ? 2 : (c[1] ? 4 : 8);
  endfunction

  // Control word: f = {out_en, auto_stop, wide, ref_mode, auto_en}
  function automatic logic [31:0] cw(input logic [1:0] d,
                                     input logic [4:0] f,
                                     input logic [2:0] sel);
    return {22'h0, d, f, sel};
  endfunction

  // One classic Wishbone cycle; waits for ack under a bound
  task automatic wb(input logic [7:0] a, input logic we,
                    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    wb_adr_i <= a;
    wb_we_i <= we;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      report_and_stop();
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(a, 1'b1, d);
    repeat (2) @(posedge mclk);
  endtask

  task automatic rd(input logic [7:0] a);
    wb(a, 1'b0, 32'h0);
  endtask

  task automatic clear_counts();
    @(posedge mclk);
    clr <= 1'b1;
    @(posedge mclk);
    clr <= 1'b0;
  endtask

  task automatic measure(input int cycles);
    clear_counts();
    repeat (cycles) @(posedge mclk);
  endtask

  initial begin
    void'($urandom(32'h449b));
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    // Reset values, unmapped place, free-running PLL while unlocked
    rd(clkgen_pkg::CTRL_OFS);
    check(q === 32'h0000_0008, "ctrl reset");
    wr(8'h0c, 32'hffff_ffff);
    rd(8'h0c);
    check(q === 32'h0, "unmapped read");
    rd(clkgen_pkg::STAT_OFS);
    check(q[2:0] === clkgen_pkg::RATIO_128, "unlocked ratio");
    check(osc_o === 1'b1, "osc at reset");
    measure(512);
    check(near(sys_n, pll_n / 8), "free-run sys");
    $display("test reset done");
    // Manual codes at random PLL rates, all slow enough for 512
    pll_lock_in <= 1'b1;
    foreach (codes[i]) begin
      pll_half = $urandom_range(4, 2);
      wr(clkgen_pkg::CTRL_OFS, cw(2'h0, 5'h00, codes[i]));
      rd(clkgen_pkg::STAT_OFS);
      check(q[2:0] === codes[i], "manual ratio");
      measure(1024);
      check(near(sys_n, pll_n / div_of(codes[i])), "sys rate");
      check(near(bit_n, pll_n / 16), "bit rate");
    end
    pll_half = 2;
    measure(8192);
    check(near(frame_n, pll_n / 1024), "frame rate");
    // Auto on overrides a manual 256; slow fs gives 512
    wr(clkgen_pkg::CTRL_OFS, cw(2'h0, 5'h01, 3'h2));
    repeat (400) @(posedge mclk);
    rd(clkgen_pkg::STAT_OFS);
    check(q[2:0] === clkgen_pkg::RATIO_512 && q[6] === 1'b1, "auto");
    check(q[4] === 1'b0, "fs below range");
    rd(clkgen_pkg::FS_OFS);
    check(near(q[15:0], 24 * 5 / 4) && q[31:16] === 16'h0, "fs");
    measure(512);
    check(near(sys_n, pll_n / 2), "auto overrides");
    pll_lock_in <= 1'b0;
    repeat (20) @(posedge mclk);
    rd(clkgen_pkg::STAT_OFS);
    check(q[2:0] === clkgen_pkg::RATIO_128, "unlock ratio");
    check(q[6] === 1'b0, "valid cleared");
    rd(clkgen_pkg::FS_OFS);
    check(near(q[15:0], 24 * 5 / 4) && q[31:16] === 16'h0, "fs kept");
    $display("test ratio done");
    // Switch to reference and back with no short phases
    pll_lock_in <= 1'b1;
    wr(clkgen_pkg::CTRL_OFS, cw(2'h0, 5'h00, 3'h4));
    clear_counts();
    wr(clkgen_pkg::CTRL_OFS, cw(2'h0, 5'h02, 3'h4));
    pll_run = 1'b0;
    repeat (256) @(posedge mclk);
    pll_run = 1'b1;
    wr(clkgen_pkg::CTRL_OFS, cw(2'h0, 5'h00, 3'h4));
    repeat (256) @(posedge mclk);
    check(min_phase >= 8'h2, "runt pulse");
    wr(clkgen_pkg::CTRL_OFS, cw(2'h0, 5'h02, 3'h4));
    pll_run = 1'b0;
    measure(1024);
    check(near(sys_n, ref_n / 2), "ref sys");
    check(near(bit_n, ref_n / 16), "ref bit");
    pll_run = 1'b1;
    $display("test source done");
    // Oscillator enable over every stop, wide and source setting
    for (int i = 0; i < 8; i++) begin
      wr(clkgen_pkg::CTRL_OFS, cw(2'h0, {1'b0, i[2:0], 1'b0}, 3'h0));
      check(osc_o === (i[1] | i[0] | ~i[2]), "osc enable");
    end
    $display("test oscillator done");
    // Buffered reference output at each divider, then muted
    for (int d = 0; d < 4; d++) begin
      wr(clkgen_pkg::CTRL_OFS, cw(d[1:0], 5'h10, 3'h0));
      check(mp_oe === 4'h1, "ref out on");
      measure(1024);
      check(near(16'(mp_n), ref_n >> (d + 1)), "ref out div");
    end
    wr(clkgen_pkg::CTRL_OFS, cw(2'h0, 5'h00, 3'h0));
    check(mp_oe === 4'h0, "ref out muted");
    $display("test ref out done");
    // Clock enable low freezes the system and bit clocks
    @(posedge mclk);
    ce <= 1'b0;
    measure(64);
    check(sys_n === 16'h0 && bit_n === 16'h0, "ce freeze");
    ce <= 1'b1;
    $display("test clock enable done");
    report_and_stop();
  end
endmodule
`default_nettype wire
